/* hdl/scan_port_map.svh */
/*
 * constants of the scan test port: reset values, instruction codes, widths.
 * assumes inclusion by both ends and by the bench.
 */
`ifndef SCAN_PORT_MAP_SVH
`define SCAN_PORT_MAP_SVH
`define IR_WIDTH 4
`define IR_RESET_VALUE 4'h1
`define INSTR_BYPASS 4'hf
`define INSTR_EMU_DIR 4'h2
`define INSTR_EMU_DATA 4'h3
`define DR_WIDTH 16
`define EMU_DIR_RESET 2'h0
`define TCK_HALF_DIV 8
`define FIFO_DEPTH 16
`endif

/* hdl/scan_port_pkg.sv */
/*
 * types shared by both ends of the scan test port.
 * assumes scan_port_map.svh is on the include path.
 */
package scan_port_pkg;
    typedef enum logic [15:0] {
        TLR = 16'h0001, RTI = 16'h0002, SDS = 16'h0004, CDR = 16'h0008,
        SDR = 16'h0010, E1D = 16'h0020, PDR = 16'h0040, E2D = 16'h0080,
        UDR = 16'h0100, SIS = 16'h0200, CIR = 16'h0400, SIR = 16'h0800,
        E1I = 16'h1000, PIR = 16'h2000, E2I = 16'h4000, UIR = 16'h8000
    } tap_state_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'h1, H_LOW = 3'h2, H_HIGH = 3'h4
    } host_state_t;
endpackage : scan_port_pkg

/* hdl/scan_port_if.sv */
/*
 * wires of the scan test port between device and controller.
 * assumes the bench resolves two-way pins from the enables.
 */
interface scan_port_if;
    logic tck;
    logic tms;
    logic tdi;
    logic test_reset;
    logic tdo_o;
    logic tdo_oe;
    logic emulation_pin_zero_dev_o;
    logic emulation_pin_zero_dev_oe;
    logic emulation_pin_zero_host_o;
    logic emulation_pin_zero_host_oe;
    logic emulation_pin_zero_line;
    logic emu1_dev_o;
    logic emu1_dev_oe;
    logic emu1_host_o;
    logic emu1_host_oe;
    logic emu1_line;
    modport device (input tck, tms, tdi, test_reset, emulation_pin_zero_line, emu1_line,
        output tdo_o, tdo_oe, emulation_pin_zero_dev_o, emulation_pin_zero_dev_oe, emu1_dev_o, emu1_dev_oe);
    modport host (input tdo_o, tdo_oe, emulation_pin_zero_line, emu1_line,
        output tck, tms, tdi, test_reset, emulation_pin_zero_host_o, emulation_pin_zero_host_oe,
        emu1_host_o, emu1_host_oe);
endinterface : scan_port_if

/* hdl/word_fifo.sv */
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
module word_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic push, pop;
    always_comb begin
        o_in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
        o_out_valid = wr_reg != rd_reg;
        push = i_in_valid && o_in_ready;
        pop = o_out_valid && i_out_ready;
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
        o_out_data = mem[rd_reg[AW-1:0]];
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
        if (push) mem[wr_reg[AW-1:0]] <= i_in_data;
    end
endmodule : word_fifo

/* hdl/scan_port_device.sv */
/*
 * device end of the scan test port: tap controller, instruction and data
 * registers, emulation pins and the global output disable.
 * assumes the controller drives tck, tms, tdi and test reset on pins that
 * the core clock samples; tck must be well below a quarter of the core rate.
 */
`include "scan_port_map.svh"
// What this block does
// [R1] sample tms and tdi on tck rise
// [R2] shift tdo, change only on tck fall
// [R3] tdo floats unless shift states active
// [R4] tdo floats while output disable active
// [R5] test reset high gives scan control
// [R6] test reset low ignores scan signals
// [R7] emulation_pin_zero two-way interrupt, direction by scan
// [R8] emu1 two-way interrupt, direction by scan
// [R9] test reset low: emu1 is disable_n
// [R10] all outputs float on low,high,low
// [R11] disable used only for test, not sharing
// [R12] ready and interrupt float when disabled
// [R13] standard tap, reset low forces reset
module scan_port_device (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    // link
    scan_port_if.device LINK,
    // functional side
    input wire logic I_HOST_PORT_READY,
    input wire logic I_HOST_PORT_INTERRUPT_N,
    input wire logic I_EMULATION_PIN_ZERO_EVENT,
    input wire logic I_EMU1_EVENT,
    output logic O_HOST_PORT_READY,
    output logic O_HOST_PORT_READY_OE,
    output logic O_HOST_PORT_INTERRUPT_N,
    output logic O_HOST_PORT_INTERRUPT_N_OE,
    output logic O_OUTPUTS_DISABLED,
    output logic O_EMULATION_PIN_ZERO_SEEN,
    output logic O_EMU1_SEEN,
    output logic O_SCAN_ACTIVE
);
    // three-stage pin synchronisers: bits tck, tms, tdi, trst, emulation_pin_zero, emu1
    logic [5:0] s1_reg, s2_reg, s3_reg, f_reg, f_next;
    logic [5:0] pins;
    logic tck_rise, tck_fall;
    scan_port_pkg::tap_state_t st_reg, st_next;
    logic [`IR_WIDTH-1:0] ir_sh_reg, ir_sh_next, ir_reg, ir_next;
    logic [`DR_WIDTH-1:0] dr_sh_reg, dr_sh_next;
    logic [1:0] dir_reg, dir_next, ev_reg, ev_next;
    logic tdo_reg, tdo_next, tdo_en_reg, tdo_en_next;
    logic trst, disable_active;

    always_comb begin
        pins = {LINK.emu1_line, LINK.emulation_pin_zero_line, LINK.test_reset, LINK.tdi,
            LINK.tms, LINK.tck};
        // a change counts only once stages two and three agree
        f_next = f_reg;
        for (int i = 0; i < 6; i++) begin
            if (s2_reg[i] == s3_reg[i]) f_next[i] = s3_reg[i];
        end
    end
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            f_reg <= '0;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            f_reg <= f_next;
        end
    end

    assign trst = f_reg[3];
    assign tck_rise = trst && f_next[0] && !f_reg[0]; // see [R1] [R6]
    assign tck_fall = trst && !f_next[0] && f_reg[0]; // see [R2] [R6]
    // the disable input is only honoured in functional mode
    assign disable_active = !trst && f_reg[4] && !f_reg[5]; // see [R9] [R10] [R11]

    always_comb begin
        st_next = st_reg;
        ir_sh_next = ir_sh_reg;
        ir_next = ir_reg;
        dr_sh_next = dr_sh_reg;
        dir_next = dir_reg;
        ev_next = ev_reg;
        tdo_next = tdo_reg;
        tdo_en_next = tdo_en_reg;
        if (!trst) begin
            st_next = scan_port_pkg::TLR; // see [R13] [R6]
            ir_next = `IR_RESET_VALUE;
            dir_next = `EMU_DIR_RESET;
            tdo_en_next = 1'b0;
        end else if (tck_rise) begin
            unique case (st_reg) // see [R13] [R1]
                scan_port_pkg::TLR: st_next = f_reg[1] ? scan_port_pkg::TLR : scan_port_pkg::RTI;
                scan_port_pkg::RTI: st_next = f_reg[1] ? scan_port_pkg::SDS : scan_port_pkg::RTI;
                scan_port_pkg::SDS: st_next = f_reg[1] ? scan_port_pkg::SIS : scan_port_pkg::CDR;
                scan_port_pkg::CDR: st_next = f_reg[1] ? scan_port_pkg::E1D : scan_port_pkg::SDR;
                scan_port_pkg::SDR: st_next = f_reg[1] ? scan_port_pkg::E1D : scan_port_pkg::SDR;
                scan_port_pkg::E1D: st_next = f_reg[1] ? scan_port_pkg::UDR : scan_port_pkg::PDR;
                scan_port_pkg::PDR: st_next = f_reg[1] ? scan_port_pkg::E2D : scan_port_pkg::PDR;
                scan_port_pkg::E2D: st_next = f_reg[1] ? scan_port_pkg::UDR : scan_port_pkg::SDR;
                scan_port_pkg::UDR: st_next = f_reg[1] ? scan_port_pkg::SDS : scan_port_pkg::RTI;
                scan_port_pkg::SIS: st_next = f_reg[1] ? scan_port_pkg::TLR : scan_port_pkg::CIR;
                scan_port_pkg::CIR: st_next = f_reg[1] ? scan_port_pkg::E1I : scan_port_pkg::SIR;
                scan_port_pkg::SIR: st_next = f_reg[1] ? scan_port_pkg::E1I : scan_port_pkg::SIR;
                scan_port_pkg::E1I: st_next = f_reg[1] ? scan_port_pkg::UIR : scan_port_pkg::PIR;
                scan_port_pkg::PIR: st_next = f_reg[1] ? scan_port_pkg::E2I : scan_port_pkg::PIR;
                scan_port_pkg::E2I: st_next = f_reg[1] ? scan_port_pkg::UIR : scan_port_pkg::SIR;
                scan_port_pkg::UIR: st_next = f_reg[1] ? scan_port_pkg::SDS : scan_port_pkg::RTI;
                default: st_next = scan_port_pkg::TLR;
            endcase
            unique case (st_reg)
                scan_port_pkg::TLR: ir_next = `IR_RESET_VALUE;
                scan_port_pkg::CIR: ir_sh_next = `IR_RESET_VALUE;
                scan_port_pkg::SIR: ir_sh_next = {f_reg[2], ir_sh_reg[`IR_WIDTH-1:1]}; // see [R1]
                scan_port_pkg::UIR: ir_next = ir_sh_reg;
                scan_port_pkg::CDR: dr_sh_next = {12'h000, f_reg[5], f_reg[4], dir_reg};
                scan_port_pkg::SDR: dr_sh_next = {f_reg[2], dr_sh_reg[`DR_WIDTH-1:1]}; // see [R1]
                scan_port_pkg::UDR: begin
                    // emulation pin direction is set only through the scan chain
                    if (ir_reg == `INSTR_EMU_DIR) dir_next = dr_sh_reg[1:0]; // see [R7] [R8]
                end
                default: ;
            endcase
        end else if (tck_fall) begin
            // bypass is one bit long, the others shift their lsb
            tdo_next = (st_reg == scan_port_pkg::SIR) ? ir_sh_reg[0] :
                (ir_reg == `INSTR_BYPASS) ? dr_sh_reg[`DR_WIDTH-1] : dr_sh_reg[0]; // see [R2]
            tdo_en_next = (st_reg == scan_port_pkg::SIR) ||
                (st_reg == scan_port_pkg::SDR); // see [R3]
        end
        // emulator events are sticky; a new one wins over the clear by update
        ev_next = ev_next | (trst ? {f_reg[5] & ~dir_reg[1], f_reg[4] & ~dir_reg[0]} : 2'h0);
        if (trst && tck_rise && st_reg == scan_port_pkg::UDR && ir_reg == `INSTR_EMU_DATA) begin
            ev_next = {f_reg[5] & ~dir_reg[1], f_reg[4] & ~dir_reg[0]};
        end
    end
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            st_reg <= scan_port_pkg::TLR;
            ir_sh_reg <= '0;
            ir_reg <= `IR_RESET_VALUE;
            dr_sh_reg <= '0;
            dir_reg <= `EMU_DIR_RESET;
            ev_reg <= 2'h0;
            tdo_reg <= 1'b0;
            tdo_en_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            ir_sh_reg <= ir_sh_next;
            ir_reg <= ir_next;
            dr_sh_reg <= dr_sh_next;
            dir_reg <= dir_next;
            ev_reg <= ev_next;
            tdo_reg <= tdo_next;
            tdo_en_reg <= tdo_en_next;
        end
    end

    always_comb begin
        LINK.tdo_o = tdo_reg;
        LINK.tdo_oe = tdo_en_reg && trst && !disable_active; // see [R3] [R4]
        LINK.emulation_pin_zero_dev_o = I_EMULATION_PIN_ZERO_EVENT;
        LINK.emulation_pin_zero_dev_oe = trst && dir_reg[0]; // see [R5] [R7]
        LINK.emu1_dev_o = I_EMU1_EVENT;
        LINK.emu1_dev_oe = trst && dir_reg[1]; // see [R8] [R9]
        O_HOST_PORT_READY = I_HOST_PORT_READY;
        O_HOST_PORT_READY_OE = !disable_active; // see [R12] [R10]
        O_HOST_PORT_INTERRUPT_N = I_HOST_PORT_INTERRUPT_N;
        O_HOST_PORT_INTERRUPT_N_OE = !disable_active; // see [R12] [R10]
        O_OUTPUTS_DISABLED = disable_active;
        O_EMULATION_PIN_ZERO_SEEN = ev_reg[0];
        O_EMU1_SEEN = ev_reg[1];
        O_SCAN_ACTIVE = trst; // see [R5]
    end
endmodule : scan_port_device

/* hdl/scan_port_host.sv */
/*
 * controller end of the scan test port: makes tck by dividing the core
 * clock and plays {tms, tdi} step pairs from a fifo.
 * assumes the device samples pins with its own clock.
 */
`include "scan_port_map.svh"
module scan_port_host #(
    parameter int HALF_DIV = `TCK_HALF_DIV,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    // link
    scan_port_if.host LINK,
    // step commands: {tms, tdi}
    input wire logic I_STEP_VALID,
    output logic O_STEP_READY,
    input wire logic [1:0] I_STEP_DATA,
    // mode and emulation pins
    input wire logic I_TEST_RESET,
    input wire logic I_EMULATION_PIN_ZERO_DRIVE,
    input wire logic I_EMULATION_PIN_ZERO_LEVEL,
    input wire logic I_OUTPUT_DISABLE_N,
    // captured tdo per step
    output logic O_TDO_VALID,
    output logic O_TDO_BIT,
    output logic O_TDO_DRIVEN
);
    initial begin
        if (HALF_DIV < 4) $error("tck half period too short for the device sampler");
    end
    logic fifo_valid, fifo_pop;
    logic [1:0] fifo_data;
    word_fifo #(.WIDTH(2), .DEPTH(DEPTH)) u_fifo (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_in_valid(I_STEP_VALID),
        .o_in_ready(O_STEP_READY),
        .i_in_data(I_STEP_DATA),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_data)
    );
    scan_port_pkg::host_state_t st_reg, st_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [1:0] pin_reg, pin_next;
    logic tck_reg, tck_next, tv_reg, tv_next, tb_reg, tb_next, td_reg, td_next;
    logic done;
    assign done = cnt_reg == 16'(HALF_DIV - 1);
    always_comb begin
        st_next = st_reg;
        cnt_next = done ? 16'h0000 : cnt_reg + 16'h0001;
        pin_next = pin_reg;
        tck_next = tck_reg;
        tv_next = 1'b0;
        tb_next = tb_reg;
        td_next = td_reg;
        fifo_pop = 1'b0;
        unique case (st_reg)
            scan_port_pkg::H_IDLE: begin
                cnt_next = 16'h0000;
                if (fifo_valid) begin
                    fifo_pop = 1'b1;
                    pin_next = fifo_data;
                    st_next = scan_port_pkg::H_LOW;
                end
            end
            scan_port_pkg::H_LOW: if (done) begin
                // device changes tdo on the fall, so sampling at the rise is safe
                tck_next = 1'b1;
                tv_next = 1'b1;
                tb_next = LINK.tdo_o;
                td_next = LINK.tdo_oe;
                st_next = scan_port_pkg::H_HIGH;
            end
            scan_port_pkg::H_HIGH: if (done) begin
                tck_next = 1'b0;
                st_next = scan_port_pkg::H_IDLE;
            end
            default: st_next = scan_port_pkg::H_IDLE;
        endcase
    end
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            st_reg <= scan_port_pkg::H_IDLE;
            cnt_reg <= 16'h0000;
            pin_reg <= 2'h3;
            tck_reg <= 1'b0;
            tv_reg <= 1'b0;
            tb_reg <= 1'b0;
            td_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            pin_reg <= pin_next;
            tck_reg <= tck_next;
            tv_reg <= tv_next;
            tb_reg <= tb_next;
            td_reg <= td_next;
        end
    end
    always_comb begin
        LINK.tck = tck_reg;
        LINK.tms = pin_reg[1];
        LINK.tdi = pin_reg[0];
        LINK.test_reset = I_TEST_RESET; // see [R5] [R6]
        // in functional mode emulation_pin_zero high with emu1 low floats the device; see [R10] [R11]
        LINK.emulation_pin_zero_host_o = I_EMULATION_PIN_ZERO_LEVEL;
        LINK.emulation_pin_zero_host_oe = I_EMULATION_PIN_ZERO_DRIVE; // see [R7]
        LINK.emu1_host_o = I_OUTPUT_DISABLE_N;
        LINK.emu1_host_oe = !I_TEST_RESET || !I_OUTPUT_DISABLE_N; // see [R8] [R9]
        O_TDO_VALID = tv_reg;
        O_TDO_BIT = tb_reg;
        O_TDO_DRIVEN = td_reg;
    end
endmodule : scan_port_host

/* dv/scan_port_assertions.sv */
/* checker of the scan link between the controller end and the device end.
   assumes the bench instantiates it beside the link, on the core clock. */
module scan_port_assertions (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    // link wires
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic test_reset,
    input wire logic tdo_o,
    input wire logic tdo_oe,
    input wire logic emulation_pin_zero_dev_oe,
    input wire logic emu1_dev_oe,
    input wire logic emulation_pin_zero_line,
    input wire logic emu1_line
);
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RST);
    property p_inputs_steady;
        $rose(tck) |-> ($stable(tms) && $stable(tdi)) [*4];
    endproperty
    a_inputs_steady: assert property (p_inputs_steady)
        else $error("tms or tdi moved around tck rise");
    property p_tck_high;
        $rose(tck) |-> tck [*8] ##1 !tck;
    endproperty
    a_tck_high: assert property (p_tck_high)
        else $error("tck high phase not eight cycles");
    // the device sees tck late, so tdo must move while tck is still low
    property p_tdo_on_fall;
        test_reset && $changed(tdo_o) |-> !tck;
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall)
        else $error("tdo changed while tck high");
    property p_oe_on_fall;
        test_reset && $changed(tdo_oe) |-> !tck;
    endproperty
    a_oe_on_fall: assert property (p_oe_on_fall)
        else $error("tdo enable changed while tck high");
    property p_oe_needs_scan;
        $rose(tdo_oe) |-> test_reset && !tck;
    endproperty
    a_oe_needs_scan: assert property (p_oe_needs_scan)
        else $error("tdo driven outside scan control");
    property p_disabled_floats;
        (!test_reset && emulation_pin_zero_line && !emu1_line) [*8] |-> !tdo_oe;
    endproperty
    a_disabled_floats: assert property (p_disabled_floats)
        else $error("tdo driven while outputs disabled");
    property p_functional_quiet;
        (!test_reset) [*8] |-> !tdo_oe && !emu1_dev_oe;
    endproperty
    a_functional_quiet: assert property (p_functional_quiet)
        else $error("scan pins driven in functional mode");
    property p_emu_drive_scan;
        $rose(emulation_pin_zero_dev_oe) || $rose(emu1_dev_oe) |-> test_reset;
    endproperty
    a_emu_drive_scan: assert property (p_emu_drive_scan)
        else $error("emulation pin driven without scan control");
    property p_reset_quiet;
        $fell(I_RST) |-> !tdo_oe && !emulation_pin_zero_dev_oe && !emu1_dev_oe;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("pins driven right after reset");
endmodule : scan_port_assertions

/* dv/scan_test_port_output_disable_tb_top.sv */
/* bench of the scan test port: controller end and device end face each other.
   assumes the design files and scan_port_map.svh are on the compile paths. */
`include "scan_port_map.svh"
module scan_test_port_output_disable_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [3:0] ir; logic [15:0] din; logic [15:0] dout; logic [1:0] oe;} row_t;
    // capture is {emu1 line, emulation_pin_zero line, dir}; each row sees the dir of the row before
    row_t rows [5] = '{'{`INSTR_EMU_DIR, 16'h0001, 16'h000c, 2'h1},
        '{`INSTR_EMU_DIR, 16'h0002, 16'h0009, 2'h2}, '{`INSTR_EMU_DIR, 16'h0000, 16'h000e, 2'h0},
        '{`INSTR_EMU_DIR, 16'h0000, 16'h000c, 2'h0}, '{`INSTR_BYPASS, 16'h00a5, 16'h014a, 2'h0}};
    logic clk, rst, step_valid, step_ready, test_reset, emulation_pin_zero_drive, emulation_pin_zero_level, off_n;
    logic [1:0] step_data;
    logic tdo_valid, tdo_bit, tdo_driven, hp_ready, hp_ready_oe, hp_int_n, hp_int_oe;
    logic disabled, emulation_pin_zero_seen, emu1_seen, scan_active;
    logic [1:0] samp [$];
    int num_errors = 0, checks = 0, pushed = 0, refused = 0, base = 0;
    scan_port_if link ();
    // undriven emulation lines are pulled high; a fight shows as unknown
    assign link.emulation_pin_zero_line = (link.emulation_pin_zero_dev_oe && link.emulation_pin_zero_host_oe
        && link.emulation_pin_zero_dev_o !== link.emulation_pin_zero_host_o) ? 1'hx : link.emulation_pin_zero_dev_oe ? link.emulation_pin_zero_dev_o
        : link.emulation_pin_zero_host_oe ? link.emulation_pin_zero_host_o : 1'h1;
    assign link.emu1_line = (link.emu1_dev_oe && link.emu1_host_oe
        && link.emu1_dev_o !== link.emu1_host_o) ? 1'hx : link.emu1_dev_oe ? link.emu1_dev_o
        : link.emu1_host_oe ? link.emu1_host_o : 1'h1;
    scan_port_host scan_port_host_inst (.I_CORE_CLK(clk), .I_RST(rst), .LINK(link),
        .I_STEP_VALID(step_valid), .O_STEP_READY(step_ready), .I_STEP_DATA(step_data),
        .I_TEST_RESET(test_reset), .I_EMULATION_PIN_ZERO_DRIVE(emulation_pin_zero_drive), .I_EMULATION_PIN_ZERO_LEVEL(emulation_pin_zero_level),
        .I_OUTPUT_DISABLE_N(off_n), .O_TDO_VALID(tdo_valid), .O_TDO_BIT(tdo_bit),
        .O_TDO_DRIVEN(tdo_driven));
    scan_port_device scan_port_device_inst (.I_CORE_CLK(clk), .I_RST(rst), .LINK(link),
        .I_HOST_PORT_READY(1'h1), .I_HOST_PORT_INTERRUPT_N(1'h0), .I_EMULATION_PIN_ZERO_EVENT(1'h0),
        .I_EMU1_EVENT(1'h1), .O_HOST_PORT_READY(hp_ready), .O_HOST_PORT_READY_OE(hp_ready_oe),
        .O_HOST_PORT_INTERRUPT_N(hp_int_n), .O_HOST_PORT_INTERRUPT_N_OE(hp_int_oe),
        .O_OUTPUTS_DISABLED(disabled), .O_EMULATION_PIN_ZERO_SEEN(emulation_pin_zero_seen), .O_EMU1_SEEN(emu1_seen),
        .O_SCAN_ACTIVE(scan_active));
    scan_port_assertions scan_port_assertions_inst (.I_CORE_CLK(clk), .I_RST(rst),
        .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .test_reset(link.test_reset),
        .tdo_o(link.tdo_o), .tdo_oe(link.tdo_oe), .emulation_pin_zero_dev_oe(link.emulation_pin_zero_dev_oe),
        .emu1_dev_oe(link.emu1_dev_oe), .emulation_pin_zero_line(link.emulation_pin_zero_line), .emu1_line(link.emu1_line));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk) begin
        if (tdo_valid === 1'h1) samp.push_back({tdo_driven, tdo_bit});
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask : check
    // entered at a falling edge; valid stays up so steps go back to back
    task automatic push(input logic tms, input logic tdi);
        int n;
        n = 0;
        step_valid = 1'h1;
        step_data = {tms, tdi};
        while (step_ready !== 1'h1 && n < 1000) begin
            refused++;
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        pushed++;
    endtask : push
    task automatic wait_samp(input int cnt);
        int n;
        n = 0;
        step_valid = 1'h0;
        while (samp.size() < cnt && n < 4000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
    endtask : wait_samp
    task automatic scan_ir(input logic [3:0] ir);
        for (int i = 0; i < 4; i++) push(i < 2, 1'h0);
        for (int i = 0; i < 4; i++) push(i == 3, ir[i]);
        push(1'h1, 1'h0);
        push(1'h0, 1'h0);
        wait_samp(pushed);
    endtask : scan_ir
    task automatic scan_dr(input int r);
        base = pushed;
        for (int i = 0; i < 3; i++) push(i == 0, 1'h0);
        for (int i = 0; i < 16; i++) push(i == 15, rows[r].din[i]);
        push(1'h1, 1'h0);
        push(1'h0, 1'h0);
        wait_samp(base + 21);
        // the device sees the last tck rise through its synchroniser, a few cycles late
        repeat (8) @(negedge clk);
        for (int i = 0; i < 16; i++) check("tdo", {15'h1, rows[r].dout[i]}, 16'(samp[base + 3 + i]));
        check("tdo_before", 16'h0, 16'(samp[base + 2][1]));
        check("tdo_after", 16'h0, 16'(samp[base + 19][1]));
        check("emu_oe", 16'(rows[r].oe), {14'h0, link.emu1_dev_oe, link.emulation_pin_zero_dev_oe});
    endtask : scan_dr
    task automatic report_and_stop();
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        rst = 1'h1;
        step_valid = 1'h0;
        step_data = 2'h0;
        test_reset = 1'h1;
        emulation_pin_zero_drive = 1'h0;
        emulation_pin_zero_level = 1'h1;
        off_n = 1'h1;
        repeat (10) @(negedge clk);
        rst = 1'h0;
        @(negedge clk);
        for (int i = 0; i < 6; i++) push(i < 5, 1'h0);
        wait_samp(pushed);
        check("scan_active", 16'h1, 16'(scan_active));
        for (int r = 0; r < 5; r++) begin
            scan_ir(rows[r].ir);
            scan_dr(r);
        end
        check("emulation_pin_zero_seen", 16'h1, 16'(emulation_pin_zero_seen));
        check("emu1_seen", 16'h1, 16'(emu1_seen));
        // pins are synchronised in the device, so each level gets eight cycles
        for (int k = 0; k < 8; k++) begin
            {test_reset, emulation_pin_zero_level, off_n} = k[2:0];
            emulation_pin_zero_drive = 1'h1;
            repeat (8) @(negedge clk);
            check("disabled", 16'(k == 2), 16'(disabled));
            check("ready_oe", 16'(k != 2), 16'(hp_ready_oe));
            check("int_oe", 16'(k != 2), 16'(hp_int_oe));
            check("ready", 16'h1, 16'(hp_ready));
            check("int_n", 16'h0, 16'(hp_int_n));
            if (k == 2) check("tdo_oe", 16'h0, 16'(link.tdo_oe));
        end
        emulation_pin_zero_drive = 1'h0;
        off_n = 1'h1;
        test_reset = 1'h0;
        repeat (8) @(negedge clk);
        check("scan_active", 16'h0, 16'(scan_active));
        // burst outruns the tck rate: the step buffer must fill and refuse
        base = pushed;
        refused = 0;
        for (int i = 0; i < 24; i++) push(i == 0, 1'h1);
        wait_samp(base + 24);
        check("refused", 16'h1, 16'(refused > 0));
        for (int i = 0; i < 24; i++) check("tdo_driven", 16'h0, 16'(samp[base + i][1]));
        report_and_stop();
    end
endmodule : scan_test_port_output_disable_tb_top
